// >>> hw/irq_link_if.sv
// Event, clear and mask lines between the control logic and the
// sticky interrupt bank. Assumes one clock for both ends.
`timescale 1ns/1ns
interface irq_link_if #(parameter int N = 4);
  logic [N-1:0] event_set;
  logic [N-1:0] clear;
  logic [N-1:0] mask;
  logic [N-1:0] status;
  logic         irq;
  modport bank (input event_set, input clear, input mask,
                output status, output irq);
  modport ctrl (output event_set, output clear, output mask,
                input status, input irq);
endinterface : irq_link_if

// >>> hw/irq_status_bank.sv
// Sticky interrupt status bits with write-one-to-clear and a mask.
// Assumes clear pulses last one cycle and come from the bus logic.
`timescale 1ns/1ns
module irq_status_bank #(
  parameter int N = 4
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  irq_link_if.bank  link
);
  import radio_event_pkg::*;

  logic [N-1:0] status_q;
  logic         irq_q;

  // ------
  // Sticky bits, one per event
  // ------
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      // Set beats clear so an event in the clearing cycle survives
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          status_q[i] <= 1'b0;
        end else if (link.event_set[i]) begin
          status_q[i] <= 1'b1;
        end else if (link.clear[i]) begin
          status_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // Level output, one cycle behind the status bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & link.mask);
    end
  end

  assign link.status = status_q;
  assign link.irq    = irq_q;
endmodule : irq_status_bank

// >>> hw/radio_event_ctrl.sv
// Radio event and status control: FIFO fill control, transmit start,
// level detect, synthesizer lock latch, interrupts, AXI4-Lite slave.
// Assumes all inputs are synchronous to aclk and the FIFO, RSSI meter
// and synthesizer sit outside this block.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "radio_event_params.svh"
module radio_event_ctrl #(
  parameter int ADDR_W = 12,
  parameter int CNT_W  = 7
) (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]        awaddr,
  input  wire logic                     awvalid,
  output logic                          awready,
  input  wire logic [31:0]              wdata,
  input  wire logic [3:0]               wstrb,
  input  wire logic                     wvalid,
  output logic                          wready,
  output logic [1:0]                    bresp,
  output logic                          bvalid,
  input  wire logic                     bready,
  input  wire logic [ADDR_W-1:0]        araddr,
  input  wire logic                     arvalid,
  output logic                          arready,
  output logic [31:0]                   rdata,
  output logic [1:0]                    rresp,
  output logic                          rvalid,
  input  wire logic                     rready,
  // Receive side
  input  wire logic                     pattern_detect,
  input  wire radio_event_pkg::byte_t   rssi,
  input  wire logic                     rssi_valid,
  output logic                          fifo_fill_en,
  // Transmit side
  input  wire logic                     tx_request,
  input  wire logic                     packet_mode,
  input  wire logic                     fifo_full,
  input  wire logic                     fifo_not_empty,
  input  wire logic [CNT_W-1:0]         fifo_count,
  input  wire logic [CNT_W-1:0]         fifo_threshold,
  input  wire logic                     tx_last_bit,
  output logic                          tx_start,
  // Synthesizer
  input  wire logic                     synth_locked,
  output logic                          lock_pin,
  // Configuration outputs and interrupt
  output radio_event_pkg::byte_t        irq_source_cfg,
  output radio_event_pkg::byte_t        rx_filter_bw_cfg,
  output logic                          irq
);
  import radio_event_pkg::*;

  // ------
  // Storage
  // ------
  logic                  tx_start_q;
  logic                  tx_done;
  logic                  tx_done_pulse;
  byte_t                 src_map_q;
  byte_t                 level_threshold_q;
  byte_t                 filter_bw_q;
  logic [`EVT_COUNT-1:0] irq_mask_q;
  logic                  fill_mode_q;
  logic                  sync_flag_q;
  logic                  sync_armed_q;
  logic                  tx_start_sel_q;
  logic                  level_irq_enable_q;
  logic                  level_detect_flag_q;
  logic                  synth_lock_latch_q;
  logic                  lock_pin_enable_q;
  logic                  synth_locked_q;
  logic                  fifo_fill_en_q;
  logic                  lock_pin_q;
  logic                  level_set_pulse_q;
  logic                  sync_set_pulse_q;
  logic                  lock_set_pulse_q;

  // Bus state
  logic                  awready_q;
  logic                  wready_q;
  logic                  bvalid_q;
  logic [1:0]            bresp_q;
  logic                  aw_full_q;
  logic                  w_full_q;
  logic [ADDR_W-1:0]     awaddr_q;
  logic [31:0]           wdata_q;
  logic [3:0]            wstrb_q;
  logic                  arready_q;
  logic                  rvalid_q;
  logic [31:0]           rdata_q;
  logic [1:0]            rresp_q;

  // ------
  // AXI4-Lite write channel
  // ------
  logic              aw_take;
  logic              w_take;
  logic              have_aw;
  logic              have_w;
  logic              do_wr;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_word;
  logic [3:0]        wr_strb;
  logic [7:0]        wr_idx;
  logic              wr_low;
  byte_t             wd;

  // Address and data are taken in either order, then written together
  assign aw_take = awvalid & awready_q;
  assign w_take  = wvalid & wready_q;
  assign have_aw = aw_full_q | aw_take;
  assign have_w  = w_full_q | w_take;
  assign do_wr   = have_aw & have_w & ~bvalid_q;
  assign wr_addr = aw_full_q ? awaddr_q : awaddr;
  assign wr_word = w_full_q ? wdata_q : wdata;
  assign wr_strb = w_full_q ? wstrb_q : wstrb;
  assign wr_idx  = wr_addr[9:2];
  assign wr_low  = do_wr & wr_strb[0]; // Registers live in byte lane 0
  assign wd      = wr_word[7:0];

  // Write address decode
  logic wr_map;
  logic wr_fill;
  logic wr_thr;
  logic wr_bw;
  logic wr_stat;
  logic wr_mask;
  logic wr_hit;

  assign wr_map  = wr_low & (wr_idx == `IDX_IRQ_SOURCE_MAP);
  assign wr_fill = wr_low & (wr_idx == `IDX_FILL_EVENT);
  assign wr_thr  = wr_low & (wr_idx == `IDX_LEVEL_THRESHOLD);
  assign wr_bw   = wr_low & (wr_idx == `IDX_RX_FILTER_BW);
  assign wr_stat = wr_low & (wr_idx == `IDX_IRQ_STATUS);
  assign wr_mask = wr_low & (wr_idx == `IDX_IRQ_MASK);
  assign wr_hit  = (wr_addr[1:0] == 2'h0) && (wr_addr[ADDR_W-1:10] == '0)
                   && ((wr_idx == `IDX_IRQ_SOURCE_MAP)
                   || (wr_idx == `IDX_FILL_EVENT)
                   || (wr_idx == `IDX_LEVEL_THRESHOLD)
                   || (wr_idx == `IDX_RX_FILTER_BW)
                   || (wr_idx == `IDX_IRQ_STATUS)
                   || (wr_idx == `IDX_IRQ_MASK));

  // Holding registers and response; each ready drops while its own channel holds or the answer waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RESP_OKAY;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
    end else begin
      if (aw_take) awaddr_q <= awaddr;
      if (w_take) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      aw_full_q <= have_aw & ~do_wr;
      w_full_q  <= have_w & ~do_wr;
      if (do_wr) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bready) begin
        bvalid_q <= 1'b0;
      end
      awready_q <= ~(have_aw | do_wr) & ~(bvalid_q & ~bready);
      wready_q  <= ~(have_w | do_wr) & ~(bvalid_q & ~bready);
    end
  end

  // ------
  // AXI4-Lite read channel
  // ------
  irq_link_if #(.N(`EVT_COUNT)) link ();

  logic       ar_take;
  logic [7:0] rd_idx;
  logic       rd_hit;
  byte_t      fill_event_rd;
  byte_t      rd_byte;

  assign ar_take = arvalid & arready_q;
  assign rd_idx  = araddr[9:2];
  assign rd_hit  = (araddr[1:0] == 2'h0) && (araddr[ADDR_W-1:10] == '0);
  assign fill_event_rd = {fill_mode_q, sync_flag_q, tx_done,
                          tx_start_sel_q, level_irq_enable_q,
                          level_detect_flag_q, synth_lock_latch_q,
                          lock_pin_enable_q};

  // Read selection; unmapped words read zero with an error answer
  assign rd_byte =
    !rd_hit                             ? 8'h00 :
    (rd_idx == `IDX_IRQ_SOURCE_MAP)     ? src_map_q :
    (rd_idx == `IDX_FILL_EVENT)         ? fill_event_rd :
    (rd_idx == `IDX_LEVEL_THRESHOLD)    ? level_threshold_q :
    (rd_idx == `IDX_RX_FILTER_BW)       ? filter_bw_q :
    (rd_idx == `IDX_IRQ_STATUS)         ? {4'h0, link.status} :
    (rd_idx == `IDX_IRQ_MASK)           ? {4'h0, irq_mask_q} : 8'h00;

  logic rd_known;
  assign rd_known = rd_hit && ((rd_idx == `IDX_IRQ_SOURCE_MAP)
                   || (rd_idx == `IDX_FILL_EVENT)
                   || (rd_idx == `IDX_LEVEL_THRESHOLD)
                   || (rd_idx == `IDX_RX_FILTER_BW)
                   || (rd_idx == `IDX_IRQ_STATUS)
                   || (rd_idx == `IDX_IRQ_MASK));

  // Data is captured at the address edge and held until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `RESP_OKAY;
    end else if (ar_take) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= {24'h00_0000, rd_byte};
      rresp_q   <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_q & rready) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end else begin
      arready_q <= ~rvalid_q;
    end
  end

  // ------
  // Plain configuration registers
  // ------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_map_q          <= `RST_IRQ_SOURCE_MAP;
      level_threshold_q  <= `RST_LEVEL_THRESHOLD;
      filter_bw_q        <= `RST_RX_FILTER_BW;
      irq_mask_q         <= `RST_IRQ_MASK;
      fill_mode_q        <= 1'(`RST_FILL_EVENT >> `BIT_FILL_MODE);
      tx_start_sel_q     <= 1'b0;
      level_irq_enable_q <= 1'b0;
      lock_pin_enable_q  <= 1'b1;
    end else begin
      if (wr_map) src_map_q <= wd;
      if (wr_thr) level_threshold_q <= wd;
      if (wr_bw) filter_bw_q <= wd;
      if (wr_mask) irq_mask_q <= wd[`EVT_COUNT-1:0];
      if (wr_fill) begin
        fill_mode_q        <= wd[`BIT_FILL_MODE];
        tx_start_sel_q     <= wd[`BIT_TX_START_SEL];
        level_irq_enable_q <= wd[`BIT_LEVEL_IRQ_EN];
        lock_pin_enable_q  <= wd[`BIT_LOCK_PIN_EN];
      end
    end
  end

  // ------
  // Start pattern flag and FIFO fill
  // ------
  logic sync_set;
  logic sync_wr1;

  // Detection is disarmed after a hit so one pattern sets once
  assign sync_set = ~fill_mode_q & sync_armed_q & pattern_detect;
  assign sync_wr1 = wr_fill & wd[`BIT_SYNC_FLAG];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_flag_q    <= 1'b0;
      sync_armed_q   <= 1'b1;
      fifo_fill_en_q <= 1'b0;
    end else begin
      if (fill_mode_q) begin
        if (wr_fill) sync_flag_q <= wd[`BIT_SYNC_FLAG];
        sync_armed_q <= 1'b1;
      end else if (sync_set) begin
        sync_flag_q  <= 1'b1;
        sync_armed_q <= 1'b0;
      end else if (sync_wr1) begin
        sync_flag_q  <= 1'b0;
        sync_armed_q <= 1'b1;
      end
      // Fill follows the flag in both modes, one cycle late
      fifo_fill_en_q <= sync_flag_q;
    end
  end

  // ------
  // Level detect and synthesizer lock
  // ------
  logic level_hit;
  logic lock_rise;

  assign level_hit = rssi_valid & (rssi >= level_threshold_q);
  assign lock_rise = synth_locked & ~synth_locked_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_detect_flag_q <= 1'b0;
      synth_lock_latch_q  <= 1'b0;
      synth_locked_q      <= 1'b0;
      lock_pin_q          <= 1'b1;
    end else begin
      synth_locked_q <= synth_locked;
      if (level_hit) begin
        level_detect_flag_q <= 1'b1;
      end else if (wr_fill & wd[`BIT_LEVEL_FLAG]) begin
        level_detect_flag_q <= 1'b0;
      end
      if (lock_rise) begin
        synth_lock_latch_q <= 1'b1;
      end else if (wr_fill & wd[`BIT_LOCK_LATCH]) begin
        synth_lock_latch_q <= 1'b0;
      end
      // Pin parks high when the lock output is disabled
      lock_pin_q <= lock_pin_enable_q ? synth_locked : 1'b1;
    end
  end

  // ------
  // Transmit start
  // ------

  tx_start_ctrl #(.CNT_W(CNT_W)) u_tx (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .tx_request     (tx_request),
    .packet_mode    (packet_mode),
    .start_sel      (tx_start_sel_q),
    .fifo_full      (fifo_full),
    .fifo_not_empty (fifo_not_empty),
    .fifo_count     (fifo_count),
    .fifo_threshold (fifo_threshold),
    .last_bit       (tx_last_bit),
    .tx_start_q     (tx_start_q),
    .tx_done_q      (tx_done),
    .done_pulse_q   (tx_done_pulse)
  );

  // ------
  // Interrupt events
  // ------
  // Events are first-set edges so a held level raises one status bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_set_pulse_q <= 1'b0;
      sync_set_pulse_q  <= 1'b0;
      lock_set_pulse_q  <= 1'b0;
    end else begin
      level_set_pulse_q <= level_hit & ~level_detect_flag_q;
      sync_set_pulse_q  <= sync_set;
      lock_set_pulse_q  <= lock_rise;
    end
  end

  // Level event reaches the bank only while its enable is set
  assign link.event_set = {tx_done_pulse, lock_set_pulse_q,
                           level_set_pulse_q & level_irq_enable_q,
                           sync_set_pulse_q};
  assign link.clear     = wr_stat ? wd[`EVT_COUNT-1:0] : '0;
  assign link.mask      = irq_mask_q;

  irq_status_bank #(.N(`EVT_COUNT)) u_irq (
    .aclk    (aclk),
    .aresetn (aresetn),
    .link    (link)
  );

  // ------
  // Outputs
  // ------
  assign awready          = awready_q;
  assign wready           = wready_q;
  assign bvalid           = bvalid_q;
  assign bresp            = bresp_q;
  assign arready          = arready_q;
  assign rvalid           = rvalid_q;
  assign rdata            = rdata_q;
  assign rresp            = rresp_q;
  assign fifo_fill_en     = fifo_fill_en_q;
  assign tx_start         = tx_start_q;
  assign lock_pin         = lock_pin_q;
  assign irq_source_cfg   = src_map_q;
  assign rx_filter_bw_cfg = filter_bw_q;
  assign irq              = link.irq;
endmodule : radio_event_ctrl

// >>> hw/radio_event_params.svh
// Register offsets, field positions, reset values and event slots
// of the radio event and status control block.
// Assumes a 32-bit AXI4-Lite bus; each register takes one aligned word.
// Notes on behaviour
// - With fill mode 0 the FIFO is filled only after a start pattern hit.
// - With fill mode 1 the FIFO fills while the host holds the sync flag.
// - In pattern mode a hit sets the sync flag; writing 1 clears, re-arms.
// - The transmit state bit is 0 while sending and 1 after the last bit.
// - Buffered mode: select 0 waits for a full FIFO, 1 for not-empty.
// - Packet mode: select 0 waits for count >= threshold, 1 for not-empty.
// - Signal level at or above threshold sets the level flag; irq gated.
// - The level flag stays set until the host writes 1 to its bit.
// - The lock latch sets on every lock and holds until written with 1.
// - Lock pin shows the lock signal when enabled, else is held high.
// - An 8-bit read/write level threshold register resets to zero.
`ifndef RADIO_EVENT_PARAMS_SVH
`define RADIO_EVENT_PARAMS_SVH
// Register indices; byte address is four times the index
`define IDX_IRQ_SOURCE_MAP   8'h0D
`define IDX_FILL_EVENT       8'h0E
`define IDX_LEVEL_THRESHOLD  8'h0F
`define IDX_RX_FILTER_BW     8'h10
`define IDX_IRQ_STATUS       8'h20
`define IDX_IRQ_MASK         8'h21
// Reset values
`define RST_IRQ_SOURCE_MAP   8'h00
`define RST_FILL_EVENT       8'h01
`define RST_LEVEL_THRESHOLD  8'h00
`define RST_RX_FILTER_BW     8'h00
`define RST_IRQ_MASK         4'h0
// Field positions of the fill and event register
`define BIT_FILL_MODE        7
`define BIT_SYNC_FLAG        6
`define BIT_TX_DONE          5
`define BIT_TX_START_SEL     4
`define BIT_LEVEL_IRQ_EN     3
`define BIT_LEVEL_FLAG       2
`define BIT_LOCK_LATCH       1
`define BIT_LOCK_PIN_EN      0
// Event slots of the interrupt status and mask registers
`define EVT_SYNC             0
`define EVT_LEVEL            1
`define EVT_LOCK             2
`define EVT_TX_DONE          3
`define EVT_COUNT            4
// Bus answers
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2
`endif

// >>> hw/radio_event_pkg.sv
// Types shared by the radio event control files.
// Assumes the constants header is included alongside.
package radio_event_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    TX_IDLE,
    TX_WAIT,
    TX_SEND,
    TX_END
  } tx_state_t;
endpackage : radio_event_pkg

// >>> hw/tx_start_ctrl.sv
// Decides when transmission starts and reports the transmit state.
// Assumes tx_request stays high for the whole transmit mode and
// last_bit is a one-cycle pulse from the modulator feed.
`timescale 1ns/1ns
module tx_start_ctrl #(
  parameter int CNT_W = 7
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             tx_request,
  input  wire logic             packet_mode,
  input  wire logic             start_sel,
  input  wire logic             fifo_full,
  input  wire logic             fifo_not_empty,
  input  wire logic [CNT_W-1:0] fifo_count,
  input  wire logic [CNT_W-1:0] fifo_threshold,
  input  wire logic             last_bit,
  output logic                  tx_start_q,
  output logic                  tx_done_q,
  output logic                  done_pulse_q
);
  import radio_event_pkg::*;

  tx_state_t state_q;
  logic      buf_go;
  logic      pkt_go;
  logic      go;

  // Start condition per data mode and select value
  assign buf_go = start_sel ? fifo_not_empty : fifo_full;
  assign pkt_go = start_sel ? fifo_not_empty
                            : (fifo_count >= fifo_threshold);
  assign go     = packet_mode ? pkt_go : buf_go;

  // Transmit sequencing; a dropped request aborts, except that last_bit in the same cycle completes the send
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q      <= TX_IDLE;
      tx_start_q   <= 1'b0;
      tx_done_q    <= 1'b0;
      done_pulse_q <= 1'b0;
    end else begin
      done_pulse_q <= 1'b0;
      case (state_q)
        TX_IDLE: begin
          if (tx_request) begin
            state_q <= TX_WAIT;
          end
        end
        TX_WAIT: begin
          if (!tx_request) begin
            state_q <= TX_IDLE;
          end else if (go) begin
            state_q    <= TX_SEND;
            tx_start_q <= 1'b1;
            tx_done_q  <= 1'b0;
          end
        end
        TX_SEND: begin
          if (last_bit) begin
            state_q      <= TX_END;
            tx_start_q   <= 1'b0;
            tx_done_q    <= 1'b1;
            done_pulse_q <= 1'b1;
          end else if (!tx_request) begin
            state_q    <= TX_IDLE;
            tx_start_q <= 1'b0;
          end
        end
        default: begin
          if (!tx_request) begin
            state_q <= TX_IDLE;
          end
        end
      endcase
    end
  end
endmodule : tx_start_ctrl

// >>> testbench/host_model.sv
// Host model: AXI4-Lite master on the register bus.
// Assumes the bench gives aclk and a complete_run task.
`timescale 1ns/1ns
module host_model (
  input  wire logic   aclk,
  output logic [11:0] awaddr,
  output logic        awvalid,
  input  wire logic   awready,
  output logic [31:0] wdata,
  output logic [3:0]  wstrb,
  output logic        wvalid,
  input  wire logic   wready,
  input  wire logic   bvalid,
  output logic        bready,
  output logic [11:0] araddr,
  output logic        arvalid,
  input  wire logic   arready,
  input  wire logic   rvalid,
  output logic        rready
);
  initial {awaddr, araddr, wdata, wstrb} = '0;
  initial {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
  // Look at the falling edge so the taking edge is never raced
  task automatic hold(input int k);
    int n;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      if (k == 0 ? awready && wready : k == 1 ? bvalid :
          k == 2 ? arready : rvalid) break;
    end
    if (n == 40) testbench.complete_run(1'b1);
    @(posedge aclk);
  endtask : hold
  // Address and data offered together, held until taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    hold(0);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    bready  <= 1'b1;
    hold(1);
    bready  <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    hold(2);
    arvalid <= 1'b0;
    hold(3);
    rready  <= 1'b0;
  endtask : rd
endmodule : host_model

// >>> testbench/radio_event_ctrl_sva.sv
// Checker: bus and pin timing of the radio event block.
// Assumes a bind into radio_event_ctrl; sees its ports only.
`timescale 1ns/1ns
module radio_event_ctrl_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awready,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic tx_request,
  input wire logic tx_start,
  input wire logic tx_last_bit,
  input wire logic fifo_not_empty,
  input wire logic synth_locked,
  input wire logic lock_pin,
  input wire logic irq
);
  // One clock domain; checks rest while reset is low
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_write_hold: assert property (bvalid && !bready |=> bvalid)
    else $error("write answer dropped early");
  a_read_hold: assert property (rvalid && !rready |=> rvalid)
    else $error("read answer dropped early");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered next cycle");
  a_write_busy: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while answer waits");
  a_tx_abort: assert property (!tx_request |=> !tx_start)
    else $error("transmit running without request");
  a_tx_last_stop:
    assert property (tx_start && tx_last_bit |=> !tx_start)
    else $error("transmit kept running after last bit");
  a_tx_needs_data:
    assert property ($rose(tx_start) |-> $past(fifo_not_empty))
    else $error("transmit started on empty fifo");
  a_lock_pin_high:
    assert property ($past(synth_locked) |-> lock_pin)
    else $error("lock pin low while locked");
  // Main scenarios reached
  c_write: cover property (bvalid && bready);
  c_tx: cover property ($rose(tx_start));
  c_irq: cover property ($rose(irq));
endmodule : radio_event_ctrl_sva

bind radio_event_ctrl radio_event_ctrl_sva radio_event_ctrl_sva_i (.*);

// >>> testbench/testbench.sv
// Bench: reads are noted in a queue and checked by a monitor.
// Assumes host_model drives the bus of radio_event_ctrl.
`timescale 1ns/1ns
`include "radio_event_params.svh"
module testbench;
  import radio_event_pkg::*;
  localparam logic [11:0] FE = 12'(`IDX_FILL_EVENT * 4);
  localparam logic [11:0] TH = 12'(`IDX_LEVEL_THRESHOLD * 4);
  localparam logic [11:0] ST = 12'(`IDX_IRQ_STATUS * 4);
  localparam logic [11:0] MK = 12'(`IDX_IRQ_MASK * 4);
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq, lock_pin;
  logic        pattern_detect, rssi_valid, fifo_fill_en, tx_start;
  logic        tx_request, packet_mode, fifo_full, fifo_not_empty;
  logic        tx_last_bit, synth_locked;
  logic [6:0]  fifo_count, fifo_threshold;
  byte_t       rssi, irq_source_cfg, rx_filter_bw_cfg, t;
  logic [33:0] exp_q[$];
  int          failures = 0;
  int          check_count = 0;
  int          seed = 32'h101A6A07;
  int          n, i;
  always #25 aclk = ~aclk;
  radio_event_ctrl radio_event_ctrl_i (.*);
  host_model host_model_i (.*);
  task chk(input string s, input logic [33:0] e, input logic [33:0] v);
    check_count++;
    if (v !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", s, e, v);
    end
  endtask : chk
  task rd(input logic [11:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    host_model_i.rd(a);
  endtask : rd
  task tk(input int c);
    repeat (c) @(negedge aclk);
  endtask : tk
  task complete_run(input bit hang);
    if (hang) failures++;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  // Monitor: the edge after this falling edge takes the read answer
  always @(negedge aclk)
    if (rvalid === 1'b1 && rready === 1'b1)
      chk("read word", exp_q.pop_front(), {rresp, rdata});
  initial #3000000 complete_run(1'b1);
  // ------
  // Main sequence
  // ------
  initial begin
    {pattern_detect, rssi_valid, tx_request, packet_mode} = 4'h0;
    {fifo_full, fifo_not_empty, tx_last_bit, synth_locked} = 4'h0;
    {rssi, fifo_count, fifo_threshold} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(FE, 34'h01);
    rd(TH, 34'h00);
    rd(12'h300, {2'h2, 32'h0});
    // Every mode and select value of the transmit start
    for (i = 0; i < 4; i++) begin
      host_model_i.wr(FE, {3'h0, i[0], 4'h0});
      packet_mode <= i[1];
      {fifo_not_empty, fifo_full} <= 2'h2;
      {fifo_count, fifo_threshold} <= {7'h03, 7'h05};
      tx_request <= 1'b1;
      tk(4);
      chk("tx_start", {33'h0, i[0]}, tx_start);
      @(posedge aclk);
      fifo_full <= ~i[1];
      fifo_count <= 7'h05;
      for (n = 0; n < 20 && tx_start !== 1'b1; n++) @(negedge aclk);
      if (n == 20) complete_run(1'b1);
      @(posedge aclk);
      tx_last_bit <= 1'b1;
      @(posedge aclk);
      tx_last_bit <= 1'b0;
      tk(1);
      chk("tx_start", 34'h0, tx_start);
      rd(FE, {26'h0, 3'h1, i[0], 4'h0});
      {tx_request, fifo_full} <= 2'h0;
    end
    // Signal level flag against a random threshold
    t = 8'($random(seed)) | 8'h01;
    host_model_i.wr(TH, t);
    rd(TH, {26'h0, t});
    host_model_i.wr(MK, 8'h02);
    host_model_i.wr(FE, 8'h08);
    rssi <= t - 8'h01;
    rssi_valid <= 1'b1;
    rd(FE, 34'h28);
    rssi <= t;
    rd(FE, 34'h2C);
    rssi_valid <= 1'b0;
    tk(1);
    chk("irq", 34'h1, irq);
    host_model_i.wr(FE, 8'h0C);
    rd(FE, 34'h28);
    rd(ST, 34'h0A);
    host_model_i.wr(ST, 8'h0A);
    tk(2);
    chk("irq", 34'h0, irq);
    // Lock latch and lock pin
    @(posedge aclk);
    synth_locked <= 1'b1;
    rd(FE, 34'h2A);
    chk("lock_pin", 34'h1, lock_pin);
    host_model_i.wr(FE, 8'h01);
    synth_locked <= 1'b0;
    tk(3);
    chk("lock_pin", 34'h0, lock_pin);
    rd(FE, 34'h23);
    host_model_i.wr(FE, 8'h03);
    rd(FE, 34'h21);
    host_model_i.wr(FE, 8'h00);
    tk(3);
    chk("lock_pin", 34'h1, lock_pin);
    // Pattern triggered fill, then host controlled fill
    @(posedge aclk);
    pattern_detect <= 1'b1;
    @(posedge aclk);
    pattern_detect <= 1'b0;
    tk(3);
    chk("fifo_fill_en", 34'h1, fifo_fill_en);
    rd(FE, 34'h60);
    host_model_i.wr(FE, 8'h40);
    tk(2);
    chk("fifo_fill_en", 34'h0, fifo_fill_en);
    host_model_i.wr(FE, 8'h80);
    host_model_i.wr(FE, 8'hC0);
    tk(2);
    chk("fifo_fill_en", 34'h1, fifo_fill_en);
    host_model_i.wr(FE, 8'h80);
    tk(2);
    chk("fifo_fill_en", 34'h0, fifo_fill_en);
    complete_run(1'b0);
  end
endmodule : testbench
